// ### bpms_mcu_model.sv
`timescale 1ns/1ps
module bpms_mcu_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       frame_start,
   input  wire logic [7:0] lat,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic            scl,
   output logic            sda,
   output logic            frame_done
);
   logic [7:0] cnt;

   initial begin
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      scl        = 1'b1;
      sda        = 1'b1;
      frame_done = 1'b0;
      cnt        = 8'h00;
   end

   // Released data lines after a write, and address lines after a read, show the inverse, so stale values cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask

   task automatic wake(input int n);
      @(posedge clk);
      scl <= 1'b0;
      repeat (n) @(posedge clk);
      scl <= 1'b1;
   endtask

   task automatic flip_sda();
      @(posedge clk);
      sda <= ~sda;
   endtask

   // Modulator side: frame ends a random number of cycles after it starts
   always @(posedge clk) begin
      frame_done <= (cnt == 8'h01);
      if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
      else if (frame_start === 1'b1)
         cnt <= lat;
   end
endmodule

// ### bpms_pkg.sv
package bpms_pkg;
   // Core timing base
   localparam int CLK_HZ         = 10_000_000;
   localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
   localparam int QUIET_US       = 10_000;
   localparam int WAKE_LOW_US    = 1_000;
   localparam int GAP_STEP_US    = 250;
   localparam int PERIOD_STEP_US = 10_000;
   localparam int SETTLE_US      = 50;
   // Scaled per microsecond except SETTLE_CYC; microseconds times hertz would overflow a 32-bit int for the longer times
   localparam int QUIET_CYC      = QUIET_US * CYC_PER_US;
   localparam int WAKE_LOW_CYC   = WAKE_LOW_US * CYC_PER_US;
   localparam int GAP_STEP_CYC   = GAP_STEP_US * CYC_PER_US;
   localparam int PERIOD_CYC     = PERIOD_STEP_US * CYC_PER_US;
   localparam int SETTLE_CYC     = (SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int WAIT_W         = 28;
   localparam int ACT_W          = 17;

   // Register map
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_REPEAT    = 8'h01;
   localparam logic [7:0] ADDR_GAP       = 8'h02;
   localparam logic [7:0] ADDR_PERIOD_LO = 8'h03;
   localparam logic [7:0] ADDR_PERIOD_HI = 8'h04;
   localparam logic [7:0] ADDR_STATUS    = 8'h05;
   localparam int CTRL_RUN_BIT = 7;
   localparam int GAP_RND_BIT  = 5;
   localparam int STAT_BUS_BIT = 7;

   // Reset values
   localparam logic [2:0] RST_MASK   = 3'h7;
   localparam logic [7:0] RST_REPEAT = 8'hFF;
   localparam logic       RST_RND    = 1'b1;
   localparam logic [4:0] RST_GAP    = 5'h1F;
   localparam logic [9:0] RST_PERIOD = 10'h063;
   localparam logic [7:0] REPEAT_FOREVER = 8'hFF;
   localparam logic [7:0] LFSR_SEED  = 8'hA5;

   typedef enum logic [2:0] {
      ST_OFF, ST_DEEP, ST_IDLE, ST_LIGHT, ST_STANDBY, ST_TX
   } bpms_state_t;

   typedef struct packed {
      logic       run;
      logic [2:0] mask;
      logic [7:0] repeat_cnt;
      logic       rnd_en;
      logic [4:0] gap;
      logic [9:0] period;
   } bpms_cfg_t;

   typedef struct packed {
      logic xo;
      logic synth;
      logic pa;
      logic lprc;
   } bpms_pwr_t;

   localparam bpms_cfg_t CFG_RST = '{1'b0, RST_MASK, RST_REPEAT, RST_RND, RST_GAP, RST_PERIOD};
endpackage

// ### bpms_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Track off, deep, idle, light, standby, transmit states
// RULE2 - Standby: crystal, synth on; transmit adds amplifier
// RULE3 - Light keeps crystal; deep, idle crystal off
// RULE4 - Run bit set stops bus, starts transmit
// RULE5 - Ten millisecond quiet in light enters deep
// RULE6 - Any pin toggle restarts the quiet timer
// RULE7 - Clock low one millisecond wakes deep sleep
// RULE8 - Controller holds clock low before transfers
// RULE9 - Controller configures only over serial port
// RULE10 - Send until repeats exhausted, then light sleep
// RULE11 - Event spacing is period plus random delay
// RULE12 - Five-bit resend gap, 250us to 8ms
// RULE13 - Repeat count zero none, else that many
// RULE14 - Count 255 resends until run cleared
// RULE15 - Run cleared mid-event finishes that event
// RULE16 - Hardware clears run bit when done
// RULE17 - Period is 10ms times code plus one
// RULE18 - Channel mask selects channels in each event
// RULE19 - Bus accepted again once light sleep returns
module bpms_sequencer
   import bpms_pkg::*;
#(
   parameter int QUIET_CYCLES  = QUIET_CYC,
   parameter int WAKE_CYCLES   = WAKE_LOW_CYC,
   parameter int PERIOD_CYCLES = PERIOD_CYC
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   input  wire logic       FRAME_DONE,
   output bpms_pwr_t       POWER,
   output logic            BUS_ACCEPT,
   output logic            FRAME_START,
   output logic      [1:0] FRAME_CHANNEL,
   output logic      [2:0] MODE
);

   bpms_state_t             state_reg;
   bpms_cfg_t               cfg_reg;
   logic                    scl_s1, scl_s2, scl_s3;
   logic                    sda_s1, sda_s2, sda_s3;
   logic                    pin_change;
   logic [ACT_W-1:0]        act_cnt_reg;
   logic [WAIT_W-1:0]       wait_reg;
   logic [7:0]              left_reg;
   logic [2:0]              pend_reg;
   logic [1:0]              chan_reg;
   logic [7:0]              lfsr_reg;
   logic                    bus_ok;
   logic                    more_ch;
   logic                    event_end;
   logic                    stop_now;
   logic [WAIT_W-1:0]       gap_cyc;
   logic [WAIT_W-1:0]       space_cyc;

   function automatic logic [WAIT_W-1:0] steps(input logic [WAIT_W-1:0] unit,
                                              input logic [9:0]        code);
      return WAIT_W'(unit * (WAIT_W'(code) + 1'b1));
   endfunction

   function automatic logic [2:0] ch_bit(input logic [1:0] ch);
      return 3'h1 << ch;
   endfunction

   function automatic logic [1:0] first_ch(input logic [2:0] m);
      return m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2);
   endfunction

   // Pin synchronisers; the third stage only feeds change detection
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {SCL_IN, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {SDA_IN, sda_s1, sda_s2};
      end
   end

   assign pin_change = (scl_s2 != scl_s3) || (sda_s2 != sda_s3);
   assign bus_ok     = (state_reg == ST_LIGHT) && !cfg_reg.run; // RULE4 RULE19
   assign gap_cyc    = steps(WAIT_W'(GAP_STEP_CYC), {5'h00, cfg_reg.gap}); // RULE12
   // Random part reuses the resend step grid, 250us up to 8ms
   assign space_cyc  = steps(WAIT_W'(PERIOD_CYCLES), cfg_reg.period) // RULE17
                     + (cfg_reg.rnd_en ?
                        steps(WAIT_W'(GAP_STEP_CYC), {5'h00, lfsr_reg[4:0]}) :
                        WAIT_W'(0)); // RULE11
   assign more_ch    = (pend_reg & ~ch_bit(chan_reg)) != 3'h0;
   assign event_end  = ((state_reg == ST_STANDBY) && (wait_reg == '0) && (pend_reg == 3'h0))
                     || ((state_reg == ST_TX) && FRAME_DONE && !more_ch);
   // Run cleared by software is honoured only here, at the event boundary
   assign stop_now   = event_end && (!cfg_reg.run // RULE15
                     || ((cfg_reg.repeat_cnt != REPEAT_FOREVER) && (left_reg == 8'h00))); // RULE13

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         lfsr_reg <= LFSR_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      end
   end

   // Configuration; while busy only a clear of the run bit is taken
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cfg_reg <= CFG_RST;
      end else begin
         if (stop_now) begin
            cfg_reg.run <= 1'b0; // RULE16
         end
         if (REG_WR && bus_ok) begin
            case (REG_ADDR)
               ADDR_CTRL: begin
                  cfg_reg.run  <= REG_WDATA[CTRL_RUN_BIT];
                  cfg_reg.mask <= REG_WDATA[2:0]; // RULE18
               end
               ADDR_REPEAT:    cfg_reg.repeat_cnt  <= REG_WDATA;
               ADDR_GAP: begin
                  cfg_reg.rnd_en <= REG_WDATA[GAP_RND_BIT];
                  cfg_reg.gap    <= REG_WDATA[4:0];
               end
               ADDR_PERIOD_LO: cfg_reg.period[7:0] <= REG_WDATA;
               ADDR_PERIOD_HI: cfg_reg.period[9:8] <= REG_WDATA[1:0];
               default: begin
               end
            endcase
         end else if (REG_WR && (REG_ADDR == ADDR_CTRL) && !REG_WDATA[CTRL_RUN_BIT]) begin
            cfg_reg.run <= 1'b0; // RULE15
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            ADDR_CTRL:      REG_RDATA <= {cfg_reg.run, 4'h0, cfg_reg.mask};
            ADDR_REPEAT:    REG_RDATA <= cfg_reg.repeat_cnt;
            ADDR_GAP:       REG_RDATA <= {2'h0, cfg_reg.rnd_en, cfg_reg.gap};
            ADDR_PERIOD_LO: REG_RDATA <= cfg_reg.period[7:0];
            ADDR_PERIOD_HI: REG_RDATA <= {6'h00, cfg_reg.period[9:8]};
            ADDR_STATUS:    REG_RDATA <= {bus_ok, 4'h0, state_reg};
            default:        REG_RDATA <= 8'h00;
         endcase
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // Shared pin activity timer: quiet time in light, low time in deep
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         act_cnt_reg <= '0;
      end else if (state_reg == ST_LIGHT) begin
         if (pin_change || !bus_ok) begin
            act_cnt_reg <= '0; // RULE6
         end else begin
            act_cnt_reg <= act_cnt_reg + 1'b1;
         end
      end else if (state_reg == ST_DEEP) begin
         if (scl_s2) begin
            act_cnt_reg <= '0; // RULE7
         end else begin
            act_cnt_reg <= act_cnt_reg + 1'b1;
         end
      end else begin
         act_cnt_reg <= '0;
      end
   end

   // Mode sequencer
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_OFF;
         wait_reg  <= '0;
         left_reg  <= 8'h00;
         pend_reg  <= 3'h0;
         chan_reg  <= 2'h0;
      end else begin
         if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;
         end
         case (state_reg) // RULE1
            ST_OFF: begin
               state_reg <= ST_LIGHT;
            end
            ST_LIGHT: begin
               if (cfg_reg.run) begin
                  state_reg <= ST_STANDBY; // RULE4
                  wait_reg  <= WAIT_W'(SETTLE_CYC);
                  left_reg  <= cfg_reg.repeat_cnt; // RULE13
                  pend_reg  <= cfg_reg.mask; // RULE18
               end else if ((act_cnt_reg == ACT_W'(QUIET_CYCLES - 1)) && !pin_change) begin
                  state_reg <= ST_DEEP; // RULE5
               end
            end
            ST_DEEP: begin
               if ((act_cnt_reg == ACT_W'(WAKE_CYCLES - 1)) && !scl_s2) begin
                  state_reg <= ST_LIGHT; // RULE7
               end
            end
            ST_IDLE: begin
               if (wait_reg == '0) begin
                  state_reg <= ST_STANDBY;
                  wait_reg  <= WAIT_W'(SETTLE_CYC);
               end
            end
            ST_STANDBY: begin
               if ((wait_reg == '0) && (pend_reg != 3'h0)) begin
                  state_reg <= ST_TX;
                  chan_reg  <= first_ch(pend_reg);
               end
            end
            ST_TX: begin
               if (FRAME_DONE && more_ch) begin
                  state_reg <= ST_STANDBY;
                  pend_reg  <= pend_reg & ~ch_bit(chan_reg);
                  wait_reg  <= gap_cyc; // RULE12
               end
            end
            default: begin
               state_reg <= ST_OFF;
            end
         endcase
         if (event_end) begin
            if (stop_now) begin
               state_reg <= ST_LIGHT; // RULE10
            end else begin
               state_reg <= ST_IDLE;
               wait_reg  <= space_cyc; // RULE11
               pend_reg  <= cfg_reg.mask;
               if (cfg_reg.repeat_cnt != REPEAT_FOREVER) begin
                  left_reg <= left_reg - 1'b1; // RULE14
               end
            end
         end
      end
   end

   // Registered outputs trail the state by one cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         POWER         <= '0;
         MODE          <= ST_OFF;
         BUS_ACCEPT    <= 1'b0;
         FRAME_START   <= 1'b0;
         FRAME_CHANNEL <= 2'h0;
      end else begin
         MODE          <= state_reg;
         BUS_ACCEPT    <= bus_ok;
         FRAME_START   <= (state_reg == ST_STANDBY) && (wait_reg == '0) && (pend_reg != 3'h0);
         FRAME_CHANNEL <= first_ch(pend_reg);
         POWER.xo      <= (state_reg == ST_LIGHT) || (state_reg == ST_STANDBY)
                          || (state_reg == ST_TX); // RULE3
         POWER.synth   <= (state_reg == ST_STANDBY) || (state_reg == ST_TX); // RULE2
         POWER.pa      <= (state_reg == ST_TX); // RULE2
         POWER.lprc    <= (state_reg == ST_IDLE); // RULE3
      end
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_run_taken;
      (state_reg == ST_LIGHT) && cfg_reg.run;
   endsequence

   sequence s_bus_dropped;
      (state_reg == ST_STANDBY) ##1 !BUS_ACCEPT;
   endsequence

   AST_STANDBY_PWR: assert property (MODE == ST_STANDBY |-> POWER.xo && POWER.synth && !POWER.pa) // RULE2
      else $error("standby power wrong");
   AST_TX_PWR: assert property (MODE == ST_TX |-> POWER.xo && POWER.synth && POWER.pa) // RULE2
      else $error("transmit power wrong");
   AST_SLEEP_PWR: assert property ((MODE == ST_DEEP || MODE == ST_IDLE) |-> !POWER.xo // RULE3
      && (POWER.lprc == (MODE == ST_IDLE))) else $error("sleep power wrong");
   AST_LIGHT_PWR: assert property (MODE == ST_LIGHT |-> POWER.xo && !POWER.synth) // RULE3
      else $error("light sleep power wrong");
   AST_BUS_STOP: assert property (s_run_taken |=> s_bus_dropped) // RULE4
      else $error("bus not stopped on run");
   AST_QUIET: assert property ((state_reg == ST_LIGHT) && !cfg_reg.run && !pin_change // RULE5
      && (act_cnt_reg == ACT_W'(QUIET_CYCLES - 1)) |=> state_reg == ST_DEEP)
      else $error("quiet time did not enter deep sleep");
   AST_RESTART: assert property ((state_reg == ST_LIGHT) && pin_change |=> act_cnt_reg == '0) // RULE6
      else $error("toggle did not restart quiet timer");
   AST_WAKE: assert property ((state_reg == ST_DEEP) && scl_s2 |=> state_reg == ST_DEEP) // RULE7
      else $error("woke without clock low");
   AST_STOP: assert property (stop_now |=> (state_reg == ST_LIGHT) && !cfg_reg.run // RULE10
      ##1 BUS_ACCEPT) else $error("no return to light sleep after last event");
   AST_FOREVER: assert property (event_end && cfg_reg.run // RULE14
      && (cfg_reg.repeat_cnt == REPEAT_FOREVER) |=> state_reg == ST_IDLE)
      else $error("endless repeat stopped");
   AST_GAP: assert property ((state_reg == ST_TX) && FRAME_DONE && more_ch // RULE12
      |=> wait_reg == $past(gap_cyc)) else $error("resend gap wrong");

   // Event boundary that starts another round of spacing
   sequence s_event_again;
      event_end && !stop_now;
   endsequence

   AST_SETTLE: assert property (s_run_taken |=> (state_reg == ST_STANDBY) // RULE4
      && (wait_reg == WAIT_W'(SETTLE_CYC))) else $error("settle wait not loaded");
   AST_SPACE: assert property (s_event_again |=> (state_reg == ST_IDLE) // RULE11
      && (wait_reg == $past(space_cyc))) else $error("event spacing wrong");
   AST_COUNT: assert property (event_end && !stop_now // RULE13
      && (cfg_reg.repeat_cnt != REPEAT_FOREVER) |=> left_reg == $past(left_reg) - 8'h01)
      else $error("repeat count not taken");
   AST_SINGLE: assert property (event_end && (cfg_reg.repeat_cnt == 8'h00) // RULE13
      |=> state_reg == ST_LIGHT) else $error("single event repeated");
   AST_HW_CLEAR: assert property (stop_now |=> !cfg_reg.run) // RULE16
      else $error("run bit not cleared at end");
   AST_FINISH: assert property ((state_reg == ST_TX) && !cfg_reg.run && !FRAME_DONE // RULE15
      |=> state_reg == ST_TX)
      else $error("frame cut short by run clear");

   // Frame launch: the pulse leads MODE by one cycle and names an enabled channel
   AST_FRAME_GO: assert property ((state_reg == ST_STANDBY) && (wait_reg == '0) // RULE10
      && (pend_reg != 3'h0) |=> (state_reg == ST_TX) && FRAME_START)
      else $error("frame did not start");
   AST_CHANNEL: assert property (FRAME_START // RULE18
      |-> (cfg_reg.mask & ch_bit(FRAME_CHANNEL)) != 3'h0)
      else $error("frame on disabled channel");
   AST_PULSE: assert property (FRAME_START |=> !FRAME_START) // RULE10
      else $error("frame start longer than one cycle");

   // Pin timers fire on their last count only, never early
   AST_QUIET_HOLD: assert property ((state_reg == ST_LIGHT) && !cfg_reg.run // RULE6
      && (act_cnt_reg != ACT_W'(QUIET_CYCLES - 1)) |=> state_reg != ST_DEEP)
      else $error("deep sleep entered early");
   AST_WAKE_HOLD: assert property ((state_reg == ST_DEEP) && !scl_s2 // RULE7
      && (act_cnt_reg != ACT_W'(WAKE_CYCLES - 1)) |=> state_reg == ST_DEEP)
      else $error("woke before low time elapsed");
   AST_WAKE_GO: assert property ((state_reg == ST_DEEP) && !scl_s2 // RULE7
      && (act_cnt_reg == ACT_W'(WAKE_CYCLES - 1)) |=> state_reg == ST_LIGHT)
      else $error("no wake after low time");
endmodule

// ### test_beacon_power_mode_sequencer.sv
`timescale 1ns/1ps
module test_beacon_power_mode_sequencer;
   import bpms_pkg::*;
   localparam int QC = 50;
   localparam int WC = 20;
   localparam int PC = 30;
   logic       core_clk, rst, wr, rd, scl, sda, done, fstart, accept;
   logic [7:0] addr, wdata, rdata, lat, lfsr;
   logic [1:0] chan;
   logic [2:0] mode;
   bpms_pwr_t  power;
   int         cyc, done_cyc, n_mismatch, compares;
   int         exp_ch[$], exp_lo[$], exp_hi[$];

   function automatic logic [7:0] lfsr_next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   function automatic logic [7:0] pw(input logic [2:0] m);
      case (m)
         3'h2: return 8'h01;
         3'h3: return 8'h08;
         3'h4: return 8'h0C;
         3'h5: return 8'h0E;
         default: return 8'h00;
      endcase
   endfunction

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_rng(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[ERR] %0t spacing %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   bpms_sequencer #(.QUIET_CYCLES(QC), .WAKE_CYCLES(WC), .PERIOD_CYCLES(PC)) DUT (
      .CORE_CLK(core_clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda),
      .FRAME_DONE(done), .POWER(power), .BUS_ACCEPT(accept), .FRAME_START(fstart),
      .FRAME_CHANNEL(chan), .MODE(mode));

   bpms_mcu_model mcu (
      .clk(core_clk), .reg_rdata(rdata), .frame_start(fstart), .lat(lat),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .scl(scl), .sda(sda), .frame_done(done));

   // Expected frames: channel order and spacing window from the last frame end
   task automatic plan(input logic [2:0] m, input int nev, input int g, input int p,
                       input int rnd);
      int dg, de, span, k;
      dg = GAP_STEP_CYC * (g + 1);
      de = PC * (p + 1) + SETTLE_CYC + (rnd != 0 ? GAP_STEP_CYC : 0);
      span = (rnd != 0) ? 31 * GAP_STEP_CYC : 0;
      for (int e = 0; e < nev; e++) begin
         k = 0;
         for (int c = 0; c < 3; c++) begin
            if (m[c]) begin
               exp_ch.push_back(c);
               exp_lo.push_back(e == 0 && k == 0 ? -1 : (k == 0 ? de : dg));
               exp_hi.push_back(k == 0 ? de + 6 + span : dg + 4);
               k++;
            end
         end
      end
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (rst === 1'b0)
         cmp8({4'h0, power} & (mode === 3'h1 ? 8'h0E : 8'hFF), pw(mode));
      if (done === 1'b1)
         done_cyc = cyc;
      if (fstart === 1'b1) begin
         lfsr <= lfsr_next(lfsr);
         lat <= {5'h00, lfsr[2:0]} + 8'h01;
         // The pulse leaves with the state change, so MODE still shows standby
         cmp8({5'h00, mode}, 8'h04);
         cmp8({7'h00, accept}, 8'h00);
         if (exp_ch.size() == 0)
            cmp8({6'h00, chan}, 8'hFF);
         else begin
            cmp8({6'h00, chan}, 8'(exp_ch.pop_front()));
            if (exp_lo[0] >= 0)
               cmp_rng(cyc - done_cyc, exp_lo[0], exp_hi[0]);
            void'(exp_lo.pop_front());
            void'(exp_hi.pop_front());
         end
      end
   end

   // Sampled mid-cycle so that the edge's updates have landed
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      cmp8({5'h00, mode}, {5'h00, m});
   endtask

   task automatic start(input logic [2:0] m, input logic [7:0] rep, input logic [5:0] gp,
                        input logic [7:0] p);
      mcu.wr(ADDR_REPEAT, rep);
      mcu.wr(ADDR_GAP, {2'h0, gp});
      mcu.wr(ADDR_PERIOD_LO, p);
      mcu.wr(ADDR_CTRL, {5'h10, m});
      wait_mode(3'h4, 8);
   endtask

   task automatic finish(input logic [2:0] m, input int lim);
      logic [7:0] d;
      wait_mode(3'h3, lim);
      cmp8(8'(exp_ch.size()), 8'h00);
      cmp8({7'h00, accept}, 8'h01);
      mcu.rd(ADDR_CTRL, d);
      cmp8(d, {5'h00, m});
   endtask

   initial begin
      repeat (115000) @(posedge core_clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      logic [7:0] d;
      logic [7:0] ra [7];
      logic [7:0] rv [7];
      int         n;
      ra = '{ADDR_CTRL, ADDR_REPEAT, ADDR_GAP, ADDR_PERIOD_LO, ADDR_PERIOD_HI, ADDR_STATUS, 8'h07};
      rv = '{8'h07, 8'hFF, 8'h3F, 8'h63, 8'h00, 8'h83, 8'h00};
      rst = 1'b1;
      lfsr = 8'h48;
      lat = 8'h01;
      cyc = 0;
      done_cyc = 0;
      n_mismatch = 0;
      compares = 0;
      repeat (20) @(posedge core_clk);
      cmp8({mode, accept, power}, 8'h00);
      rst <= 1'b0;
      wait_mode(3'h3, 4);
      for (int i = 0; i < 7; i++) begin
         mcu.rd(ra[i], d);
         cmp8(d, rv[i]);
      end
      // Toggles kept under the quiet time, so deep sleep must not come yet
      for (int i = 0; i < 4; i++) begin
         repeat (10 + lfsr[3:0]) @(posedge core_clk);
         lfsr = lfsr_next(lfsr);
         mcu.flip_sda();
         cmp8({5'h00, mode}, 8'h03);
      end
      repeat (QC - 4) @(negedge core_clk);
      cmp8({5'h00, mode}, 8'h03);
      wait_mode(3'h1, 16);
      mcu.flip_sda();
      mcu.wake(WC / 2);
      repeat (WC) @(negedge core_clk);
      cmp8({5'h00, mode}, 8'h01);
      mcu.wake(WC + 4);
      wait_mode(3'h3, 8);
      cmp8({7'h00, accept}, 8'h01);
      plan(3'h5, 2, 0, 0, 1);
      start(3'h5, 8'h01, 6'h20, 8'h00);
      mcu.wr(ADDR_REPEAT, 8'h00);
      finish(3'h5, 100000);
      mcu.rd(ADDR_REPEAT, d);
      cmp8(d, 8'h01);
      plan(3'h7, 1, 1, 0, 0);
      start(3'h7, 8'h00, 6'h01, 8'h00);
      finish(3'h7, 20000);
      // Endless repeat, stopped by software in the middle of the third event
      plan(3'h6, 3, 0, 2, 0);
      start(3'h6, 8'hFF, 6'h00, 8'h02);
      n = 0;
      while (exp_ch.size() > 1 && n < 30000) begin
         @(negedge core_clk);
         n++;
      end
      mcu.wr(ADDR_CTRL, 8'h06);
      finish(3'h6, 10000);
      close_out();
   end
endmodule
